// [pkg/pdps_pkg.sv]
// Constants and types shared by the port power-state block
package pdps_pkg;
  localparam logic [7:0] PDPS_OFF_CAP_HDR = 8'h40;
  localparam logic [7:0] PDPS_OFF_PMCSR = 8'h44;
  localparam logic [7:0] PDPS_OFF_DEV_CAP = 8'h6c;
  localparam logic [7:0] PDPS_OFF_DEV_CTL = 8'h70;
  localparam logic [7:0] PDPS_OFF_COMMAND = 8'h04;
  localparam logic [7:0] PDPS_CAP_ID = 8'h01;
  localparam logic [7:0] PDPS_NEXT_PTR_RST = 8'h48;
  localparam logic [2:0] PDPS_VERSION_RST = 3'h3;
  localparam logic [4:0] PDPS_PME_SUPPORT = 5'h19;
  localparam logic [1:0] PDPS_PS_D0 = 2'h0;
  localparam logic [1:0] PDPS_PS_D3 = 2'h3;
  localparam int PDPS_PS_LSB = 0;
  localparam int PDPS_PME_EN_BIT = 8;
  localparam int PDPS_SEL_LSB = 9;
  localparam int PDPS_SCALE_LSB = 13;
  localparam int PDPS_PME_ST_BIT = 15;
  localparam int PDPS_DATA_LSB = 24;
  localparam int PDPS_CSPL_VAL_LSB = 18;
  localparam int PDPS_CSPL_SCL_LSB = 26;
  localparam logic [3:0] PDPS_SEL_D0_CONS = 4'h0;
  localparam logic [3:0] PDPS_SEL_D3_CONS = 4'h3;
  localparam logic [3:0] PDPS_SEL_D0_DISS = 4'h4;
  localparam logic [3:0] PDPS_SEL_D3_DISS = 4'h7;
  localparam logic [31:0] PDPS_ZERO32 = 32'h0000_0000;
  typedef enum logic [1:0] {
    PDPS_D0_UNINIT = 2'b00,
    PDPS_D0_ACTIVE = 2'b01,
    PDPS_D3_HOT = 2'b11
  } pdps_state_t;
  // Transaction kinds seen by the filter
  typedef enum logic [2:0] {
    PDPS_TLP_MEM = 3'b000,
    PDPS_TLP_IO = 3'b001,
    PDPS_TLP_CFG0 = 3'b010,
    PDPS_TLP_CFG1 = 3'b011,
    PDPS_TLP_CPL = 3'b100,
    PDPS_TLP_MSG = 3'b101
  } pdps_tlp_t;
  // Link power states reported by the link layer
  typedef enum logic [2:0] {
    PDPS_L0 = 3'b000,
    PDPS_L0S_TX = 3'b001,
    PDPS_L0S_RX = 3'b010,
    PDPS_L1 = 3'b011,
    PDPS_L23_RDY = 3'b100
  } pdps_link_t;
endpackage

// [pkg/pdps_data_if.sv]
// Interface carrying the preloaded data/scale table lookup
`timescale 1ns/10ps
`default_nettype none
interface pdps_data_if;
  logic wrEn;
  logic [1:0] wrIdx;
  logic [9:0] wrVal;
  logic [1:0] rdIdx;
  logic [9:0] rdVal;
  modport owner (output wrEn, output wrIdx, output wrVal, output rdIdx, input rdVal);
  modport store (input wrEn, input wrIdx, input wrVal, input rdIdx, output rdVal);
endinterface
`default_nettype wire

// [rtl/pdps_data_mem.sv]
// Four-entry data and scale store, registered read
`timescale 1ns/10ps
`default_nettype none
module pdps_data_mem
  import pdps_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  pdps_data_if.store dIf
);
  logic [9:0] memQ [4];
  logic [9:0] rdQ;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        memQ[i] <= 10'h000;
      end
    end else if (dIf.wrEn) begin
      memQ[dIf.wrIdx] <= dIf.wrVal;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdQ <= 10'h000;
    end else begin
      rdQ <= memQ[dIf.rdIdx];
    end
  end
  assign dIf.rdVal = rdQ;
endmodule
`default_nettype wire

// [rtl/pdps_lane_ctl.sv]
// Lane power-saving actions per link power state
`timescale 1ns/10ps
`default_nettype none
module pdps_lane_ctl
  import pdps_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [2:0] linkState,
  output logic txHiZ,
  output logic txLowPwr,
  output logic rxLowPwr,
  output logic fcTimerHold
);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txHiZ <= 1'b0;
      txLowPwr <= 1'b0;
      rxLowPwr <= 1'b0;
      fcTimerHold <= 1'b0;
    end else begin
      txHiZ <= (linkState == PDPS_L0S_TX);
      rxLowPwr <= (linkState == PDPS_L0S_RX) || (linkState == PDPS_L1)
                  || (linkState == PDPS_L23_RDY);
      txLowPwr <= (linkState == PDPS_L1) || (linkState == PDPS_L23_RDY);
      fcTimerHold <= (linkState == PDPS_L1) || (linkState == PDPS_L23_RDY);
    end
  end
  chk_lane_l1_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (linkState == PDPS_L1) |=> (txLowPwr && rxLowPwr && fcTimerHold && !txHiZ))
    else $error("lanes not low power in L1");
  chk_lane_txl0s: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (linkState == PDPS_L0S_TX) |=> (txHiZ && !txLowPwr))
    else $error("tx lanes not high impedance in tx L0s");
endmodule
`default_nettype wire

// [rtl/pdps_port_pm.sv]
// Per-port device power state machine, transaction filter and PM registers
// Overview of operation
// - Writing D3hot encoding to power state field moves port from D0 to D3hot.
// - Writing D0 encoding in D3hot, upstream link in rx L0s and downstream link in L0s, returns to D0_uninitialized.
// - After power-up stay D0_uninitialized until EEPROM load and link training finish.
// - Setting bus master, memory or I/O enable enters D0_active.
// - In D3hot accept Type 0 config and messages; memory/IO get UR; completions pass.
// - Type 1 config to a D3hot port gets UR; Type 0 completes.
// - Upstream port in D3hot requests L1 link entry.
// - Link state operations in D3hot raise a power management event.
// - Tx L0s puts tx lanes high impedance; rx L0s puts rx lanes low power.
// - L1 and L2/L3 Ready put all lanes low power and suspend FC timers.
// - Capability header low byte reads the PM capability identifier.
// - Next capability pointer defaults to the MSI capability offset.
// - Version field defaults to PM revision 1.2 value.
// - PME clock reads zero; DSI, D1 and D2 support default zero.
// - PME support bits 31, 30 and 27 read one.
// - D1 or D2 writes complete but are discarded, state unchanged.
// - Status/control bit 8 enables PME generation.
// - Data select writable by EEPROM first, then by config writes unless auto-configured.
// - Data scale EEPROM-only, chosen among four by data select.
// - Data byte EEPROM-only, chosen by select; reads zero unprogrammed.
// - PME status reads one while generating PME; cleared at reset.
// - Captured slot power limit is value times scale of 1.0 to 0.001.
`timescale 1ns/10ps
`default_nettype none
module pdps_port_pm
  import pdps_pkg::*;
#(
  parameter logic IS_UPSTREAM = 1'b1
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cfgWr,
  input wire logic cfgRd,
  input wire logic [7:0] cfgAddr,
  input wire logic [3:0] cfgBe,
  input wire logic [31:0] cfgWrData,
  output logic [31:0] cfgRdData,
  input wire logic eepWr,
  input wire logic [7:0] eepAddr,
  input wire logic [31:0] eepWrData,
  input wire logic eepLoadDone,
  input wire logic linkTrainDone,
  input wire logic [2:0] linkState,
  input wire logic dnLinkL0s,
  input wire logic linkStateOp,
  input wire logic autoConfig,
  input wire logic tlpValid,
  input wire logic [2:0] tlpKind,
  output logic tlpAccept,
  output logic tlpUnsupported,
  output logic l1EntryReq,
  output logic pmeReq,
  output logic [1:0] devState,
  output logic txHiZ,
  output logic txLowPwr,
  output logic rxLowPwr,
  output logic fcTimerHold
);
  pdps_state_t stateQ, stateD;
  logic [2:0] cmdEnQ;
  logic pmeEnQ;
  logic pmeStQ;
  logic [3:0] selQ;
  logic selOpenQ;
  logic [7:0] csplValQ;
  logic [1:0] csplSclQ;
  logic [2:0] linkSyncQ;
  logic linkUp;
  logic bootDoneQ;
  pdps_data_if dIf ();

  // Decode the four valid select encodings onto a store index
  function automatic logic [1:0] selIdx(input logic [3:0] sel);
    logic [1:0] idx;
    idx = 2'h0;
    if (sel == PDPS_SEL_D3_CONS) begin
      idx = 2'h1;
    end else if (sel == PDPS_SEL_D0_DISS) begin
      idx = 2'h2;
    end else if (sel == PDPS_SEL_D3_DISS) begin
      idx = 2'h3;
    end
    return idx;
  endfunction

  function automatic logic selValid(input logic [3:0] sel);
    return (sel == PDPS_SEL_D0_CONS) || (sel == PDPS_SEL_D3_CONS)
           || (sel == PDPS_SEL_D0_DISS) || (sel == PDPS_SEL_D3_DISS);
  endfunction

  wire logic pmcsrWr = cfgWr && (cfgAddr == PDPS_OFF_PMCSR);
  wire logic cmdWr = cfgWr && (cfgAddr == PDPS_OFF_COMMAND) && cfgBe[0];
  wire logic eepPmcsr = eepWr && (eepAddr == PDPS_OFF_PMCSR);
  wire logic eepDevCap = eepWr && (eepAddr == PDPS_OFF_DEV_CAP);
  wire logic [1:0] psWrVal = cfgWrData[PDPS_PS_LSB +: 2];

  // Link training done comes from the PHY clock region; three-stage sync
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      linkSyncQ <= 3'h0;
    end else begin
      linkSyncQ <= {linkSyncQ[1:0], linkTrainDone};
    end
  end
  assign linkUp = linkSyncQ[2] && linkSyncQ[1];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bootDoneQ <= 1'b0;
    end else if (eepLoadDone && linkUp) begin
      bootDoneQ <= 1'b1;
    end
  end

  // Command register enables, one copy per instance
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmdEnQ <= 3'h0;
    end else if (stateQ == PDPS_D3_HOT && stateD == PDPS_D0_UNINIT) begin
      // Leaving D3hot acts as a soft reset, so software must enable again
      cmdEnQ <= 3'h0;
    end else if (cmdWr) begin
      cmdEnQ <= cfgWrData[2:0];
    end
  end

  always_comb begin
    stateD = stateQ;
    case (stateQ)
      PDPS_D0_UNINIT: begin
        if (pmcsrWr && cfgBe[0] && psWrVal == PDPS_PS_D3) begin
          stateD = PDPS_D3_HOT;
        end else if (bootDoneQ && (cmdEnQ != 3'h0)) begin
          stateD = PDPS_D0_ACTIVE;
        end
      end
      PDPS_D0_ACTIVE: begin
        if (pmcsrWr && cfgBe[0] && psWrVal == PDPS_PS_D3) begin
          stateD = PDPS_D3_HOT;
        end
      end
      PDPS_D3_HOT: begin
        // D1/D2 encodings fall through: write completes, state kept
        if (pmcsrWr && cfgBe[0] && psWrVal == PDPS_PS_D0
            && linkState == PDPS_L0S_RX && dnLinkL0s) begin
          stateD = PDPS_D0_UNINIT;
        end
      end
      default: begin
        stateD = PDPS_D0_UNINIT;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stateQ <= PDPS_D0_UNINIT;
    end else begin
      stateQ <= stateD;
    end
  end
  assign devState = stateQ;

  // PME enable and status; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pmeEnQ <= 1'b0;
    end else if (pmcsrWr && cfgBe[1]) begin
      pmeEnQ <= cfgWrData[PDPS_PME_EN_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pmeStQ <= 1'b0;
    end else if (stateQ == PDPS_D3_HOT && linkStateOp && pmeEnQ) begin
      pmeStQ <= 1'b1;
    end else if (pmcsrWr && cfgBe[1] && cfgWrData[PDPS_PME_ST_BIT]) begin
      pmeStQ <= 1'b0;
    end
  end
  assign pmeReq = pmeStQ;

  // Data select: EEPROM first, then PMCSR config writes with byte 1 enabled unless auto-configured
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      selQ <= 4'h0;
      selOpenQ <= 1'b0;
    end else if (eepPmcsr) begin
      selQ <= eepWrData[PDPS_SEL_LSB +: 4];
      selOpenQ <= 1'b1;
    end else if (pmcsrWr && selOpenQ && !autoConfig && cfgBe[1]) begin
      selQ <= cfgWrData[PDPS_SEL_LSB +: 4];
    end
  end

  // EEPROM loads scale and data for the entry that its own select names
  assign dIf.wrEn = eepPmcsr && selValid(eepWrData[PDPS_SEL_LSB +: 4]);
  assign dIf.wrIdx = selIdx(eepWrData[PDPS_SEL_LSB +: 4]);
  assign dIf.wrVal = {eepWrData[PDPS_SCALE_LSB +: 2], eepWrData[PDPS_DATA_LSB +: 8]};
  assign dIf.rdIdx = selIdx(selQ);

  pdps_data_mem uMem (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .dIf(dIf)
  );

  // Captured slot power limit, loaded by EEPROM on the upstream port
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      csplValQ <= 8'h00;
      csplSclQ <= 2'h0;
    end else if (eepDevCap && IS_UPSTREAM) begin
      csplValQ <= eepWrData[PDPS_CSPL_VAL_LSB +: 8];
      csplSclQ <= eepWrData[PDPS_CSPL_SCL_LSB +: 2];
    end
  end

  // Read data registered; the table value read is the store's registered output, one cycle behind select
  logic [31:0] rdD;
  always_comb begin
    rdD = PDPS_ZERO32;
    if (cfgAddr == PDPS_OFF_CAP_HDR) begin
      rdD[7:0] = PDPS_CAP_ID;
      rdD[15:8] = PDPS_NEXT_PTR_RST;
      rdD[18:16] = PDPS_VERSION_RST;
      rdD[31:27] = PDPS_PME_SUPPORT;
    end else if (cfgAddr == PDPS_OFF_PMCSR) begin
      rdD[1:0] = (stateQ == PDPS_D3_HOT) ? PDPS_PS_D3 : PDPS_PS_D0;
      rdD[PDPS_PME_EN_BIT] = pmeEnQ;
      rdD[PDPS_SEL_LSB +: 4] = selQ;
      rdD[PDPS_PME_ST_BIT] = pmeStQ;
      if (selValid(selQ)) begin
        rdD[PDPS_SCALE_LSB +: 2] = dIf.rdVal[9:8];
        rdD[PDPS_DATA_LSB +: 8] = dIf.rdVal[7:0];
      end
    end else if (cfgAddr == PDPS_OFF_DEV_CAP) begin
      rdD[PDPS_CSPL_VAL_LSB +: 8] = csplValQ;
      rdD[PDPS_CSPL_SCL_LSB +: 2] = csplSclQ;
    end else if (cfgAddr == PDPS_OFF_COMMAND) begin
      rdD[2:0] = cmdEnQ;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfgRdData <= PDPS_ZERO32;
    end else if (cfgRd) begin
      cfgRdData <= rdD;
    end
  end

  // Transaction filter: combinational handshake
  always_comb begin
    tlpAccept = tlpValid;
    tlpUnsupported = 1'b0;
    if (tlpValid && stateQ == PDPS_D3_HOT) begin
      if (tlpKind == PDPS_TLP_MEM || tlpKind == PDPS_TLP_IO
          || tlpKind == PDPS_TLP_CFG1) begin
        tlpAccept = 1'b0;
        tlpUnsupported = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      l1EntryReq <= 1'b0;
    end else begin
      l1EntryReq <= IS_UPSTREAM && (stateQ == PDPS_D3_HOT);
    end
  end

  pdps_lane_ctl uLane (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .linkState(linkState),
    .txHiZ(txHiZ),
    .txLowPwr(txLowPwr),
    .rxLowPwr(rxLowPwr),
    .fcTimerHold(fcTimerHold)
  );

  sequence seqD3Write;
    pmcsrWr && cfgBe[0] && psWrVal == PDPS_PS_D3 && stateQ != PDPS_D3_HOT;
  endsequence
  sequence seqPmeEvent;
    stateQ == PDPS_D3_HOT && linkStateOp && pmeEnQ;
  endsequence
  chk_d3_entry_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    seqD3Write |=> stateQ == PDPS_D3_HOT)
    else $error("D3hot not entered after write");
  chk_d0_return_path: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (stateQ == PDPS_D3_HOT && stateD != PDPS_D3_HOT) |-> (linkState == PDPS_L0S_RX
      && dnLinkL0s && psWrVal == PDPS_PS_D0))
    else $error("left D3hot without D0 write in L0s");
  chk_active_needs_boot: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(stateQ == PDPS_D0_ACTIVE) |-> $past(bootDoneQ))
    else $error("D0_active before boot done");
  chk_active_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (stateQ == PDPS_D0_UNINIT && bootDoneQ && cmdEnQ != 3'h0 && !pmcsrWr)
      |=> stateQ == PDPS_D0_ACTIVE)
    else $error("D0_active not entered");
  chk_d3_filter_ur: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (tlpValid && stateQ == PDPS_D3_HOT && tlpKind != PDPS_TLP_CFG0 && tlpKind != PDPS_TLP_CPL
      && tlpKind != PDPS_TLP_MSG) |-> tlpUnsupported && !tlpAccept)
    else $error("D3hot request not answered UR");
  chk_type0_pass: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (tlpValid && (tlpKind == PDPS_TLP_CFG0 || tlpKind == PDPS_TLP_CPL)) |-> tlpAccept)
    else $error("type 0 or completion refused");
  chk_l1_request: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (stateQ == PDPS_D3_HOT) [*2] |-> l1EntryReq == IS_UPSTREAM)
    else $error("L1 entry request wrong");
  chk_pme_event_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(pmeStQ) |-> $past(pmeEnQ) && $past(stateQ == PDPS_D3_HOT) && $past(linkStateOp))
    else $error("PME raised without cause");
  chk_d1d2_discard: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pmcsrWr && cfgBe[0] && (psWrVal == 2'h1 || psWrVal == 2'h2)
      && !(stateQ == PDPS_D0_UNINIT && bootDoneQ && cmdEnQ != 3'h0)) |=> $stable(stateQ))
    else $error("D1/D2 write changed state");
  chk_pme_event_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    seqPmeEvent |=> pmeStQ)
    else $error("PME status not set by link event");
  chk_pme_gate_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!pmeEnQ && !pmeStQ) |=> !pmeStQ)
    else $error("PME raised while disabled");
  chk_sel_locked: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!selOpenQ && !eepPmcsr) |=> $stable(selQ))
    else $error("data select written before EEPROM load");
  chk_sel_auto_ro: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (autoConfig && !eepPmcsr) |=> $stable(selQ))
    else $error("data select written under auto-configuration");
  chk_pme_status_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cfgRd && cfgAddr == PDPS_OFF_PMCSR) |=> cfgRdData[PDPS_PME_ST_BIT] == $past(pmeStQ))
    else $error("PME status read back wrong");
  chk_boot_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !bootDoneQ |-> stateQ != PDPS_D0_ACTIVE)
    else $error("D0_active without boot done");
endmodule
`default_nettype wire

// [verif/pdps_link_partner.sv]
// Link partner model: trains the link, follows L1 requests and testbench link commands
`timescale 1ns/10ps
`default_nettype none
module pdps_link_partner
  import pdps_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic l1EntryReq,
  input wire logic cmdValid,
  input wire logic [2:0] cmdState,
  output logic [2:0] linkState,
  output logic dnLinkL0s,
  output logic linkTrainDone,
  output logic linkStateOp
);
  logic [4:0] trainCnt;
  logic [2:0] l1Wait;
  // Downstream side tracks receive-side L0s only, so D0 return needs an explicit command
  assign dnLinkL0s = (linkState == PDPS_L0S_RX);
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      trainCnt <= 5'h00;
      l1Wait <= 3'h0;
      linkState <= PDPS_L0;
      linkTrainDone <= 1'b0;
      linkStateOp <= 1'b0;
    end else begin
      linkStateOp <= 1'b0;
      if (trainCnt != 5'h14) trainCnt <= trainCnt + 5'h01;
      else linkTrainDone <= 1'b1;
      if (cmdValid) begin
        linkState <= cmdState;
        linkStateOp <= 1'b1;
      end else if (l1EntryReq && linkState == PDPS_L0) begin
        // Not instant: the handshake into L1 takes a few cycles
        l1Wait <= l1Wait + 3'h1;
        if (l1Wait == 3'h4) begin
          linkState <= PDPS_L1;
          linkStateOp <= 1'b1;
          l1Wait <= 3'h0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [verif/pdps_port_pm_tb.sv]
// Self-checking testbench for the port power-state block
`timescale 1ns/10ps
`default_nettype none
module pdps_port_pm_tb
  import pdps_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cfgWr = 1'b0;
  logic cfgRd = 1'b0;
  logic eepWr = 1'b0;
  logic eepLoadDone = 1'b0;
  logic tlpValid = 1'b0;
  logic cmdValid = 1'b0;
  logic autoConfig = 1'b0;
  logic [7:0] cfgAddr = 8'h00;
  logic [7:0] eepAddr = 8'h00;
  logic [3:0] cfgBe = 4'h0;
  logic [31:0] cfgWrData = 32'h0000_0000;
  logic [31:0] eepWrData = 32'h0000_0000;
  logic [2:0] tlpKind = 3'h0;
  logic [2:0] cmdState = 3'h0;
  logic [2:0] linkState;
  logic [31:0] cfgRdData;
  logic [1:0] devState;
  logic dnLinkL0s, linkTrainDone, linkStateOp, tlpAccept, tlpUnsupported;
  logic l1EntryReq, pmeReq, txHiZ, txLowPwr, rxLowPwr, fcTimerHold;
  logic [3:0] laneExp [5] = '{4'h0, 4'h8, 4'h2, 4'h7, 4'h7};
  int num_errors = 0;
  int check_count = 0;

  always #5 clk_sys = ~clk_sys;

  pdps_port_pm uut (.clk_sys(clk_sys), .rst_n(rst_n), .cfgWr(cfgWr), .cfgRd(cfgRd),
    .cfgAddr(cfgAddr), .cfgBe(cfgBe), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
    .eepWr(eepWr), .eepAddr(eepAddr), .eepWrData(eepWrData), .eepLoadDone(eepLoadDone),
    .linkTrainDone(linkTrainDone), .linkState(linkState), .dnLinkL0s(dnLinkL0s),
    .linkStateOp(linkStateOp), .autoConfig(autoConfig), .tlpValid(tlpValid), .tlpKind(tlpKind),
    .tlpAccept(tlpAccept), .tlpUnsupported(tlpUnsupported), .l1EntryReq(l1EntryReq),
    .pmeReq(pmeReq), .devState(devState), .txHiZ(txHiZ), .txLowPwr(txLowPwr),
    .rxLowPwr(rxLowPwr), .fcTimerHold(fcTimerHold));

  pdps_link_partner partner (.clk_sys(clk_sys), .rst_n(rst_n), .l1EntryReq(l1EntryReq),
    .cmdValid(cmdValid), .cmdState(cmdState), .linkState(linkState), .dnLinkL0s(dnLinkL0s),
    .linkTrainDone(linkTrainDone), .linkStateOp(linkStateOp));

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic cfgW(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge clk_sys);
    cfgWr = 1'b1;
    cfgAddr = a;
    cfgBe = be;
    cfgWrData = d;
    @(negedge clk_sys);
    cfgWr = 1'b0;
  endtask
  // Read data is registered, so it is compared one full cycle after the strobe
  task automatic cfgR(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string n);
    @(negedge clk_sys);
    cfgRd = 1'b1;
    cfgAddr = a;
    @(negedge clk_sys);
    cfgRd = 1'b0;
    @(negedge clk_sys);
    check(n, e, cfgRdData & m);
  endtask
  task automatic eepW(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    eepWr = 1'b1;
    eepAddr = a;
    eepWrData = d;
    @(negedge clk_sys);
    eepWr = 1'b0;
  endtask
  task automatic linkCmd(input logic [2:0] s);
    @(negedge clk_sys);
    cmdValid = 1'b1;
    cmdState = s;
    @(negedge clk_sys);
    cmdValid = 1'b0;
    idle(3);
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    summarize();
  end

  initial begin
    idle(8);
    rst_n = 1'b1;
    check("state after reset", {30'h0, PDPS_D0_UNINIT}, {30'h0, devState});
    cfgR(PDPS_OFF_CAP_HDR, 32'hFFFF_FFFF, 32'hC803_4801, "cap header");
    cfgR(PDPS_OFF_PMCSR, 32'hFFFF_FFFF, 32'h0000_0000, "status control");
    cfgR(8'h08, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
    cfgW(PDPS_OFF_COMMAND, 4'h1, 32'h0000_0001);
    idle(2);
    check("state before boot", {30'h0, PDPS_D0_UNINIT}, {30'h0, devState});
    cfgW(PDPS_OFF_PMCSR, 4'h2, 32'h0000_0600);
    idle(2);
    cfgR(PDPS_OFF_PMCSR, 32'h0000_1E00, 32'h0000_0000, "select locked");
    // Select 3, scale 2, data 5A from the EEPROM path
    eepW(PDPS_OFF_PMCSR, 32'h5A00_4600);
    eepW(PDPS_OFF_DEV_CAP, 32'h0C64_0000);
    eepLoadDone = 1'b1;
    idle(30);
    cfgW(PDPS_OFF_COMMAND, 4'h1, 32'h0000_0004);
    idle(2);
    check("state active", {30'h0, PDPS_D0_ACTIVE}, {30'h0, devState});
    cfgR(PDPS_OFF_DEV_CAP, 32'h0FFC_0000, 32'h0C64_0000, "slot limit");
    cfgR(PDPS_OFF_PMCSR, 32'hFFFF_FFFF, 32'h5A00_4600, "data entry 3");
    cfgW(PDPS_OFF_PMCSR, 4'h2, 32'h0000_0000);
    idle(2);
    cfgR(PDPS_OFF_PMCSR, 32'hFFFF_FFFF, 32'h0000_0000, "data entry 0");
    cfgW(PDPS_OFF_PMCSR, 4'hE, 32'hFF00_6600);
    idle(2);
    cfgR(PDPS_OFF_PMCSR, 32'hFFFF_FFFF, 32'h5A00_4600, "data not writable");
    autoConfig = 1'b1;
    cfgW(PDPS_OFF_PMCSR, 4'h2, 32'h0000_0000);
    idle(2);
    cfgR(PDPS_OFF_PMCSR, 32'h0000_1E00, 32'h0000_0600, "select read only");
    autoConfig = 1'b0;
    for (int ps = 1; ps < 3; ps++) begin
      cfgW(PDPS_OFF_PMCSR, 4'h1, 32'(ps));
      idle(2);
      check("d1 d2 discarded", {30'h0, PDPS_D0_ACTIVE}, {30'h0, devState});
    end
    cfgW(PDPS_OFF_PMCSR, 4'h1, 32'h0000_0003);
    idle(2);
    check("state d3", {30'h0, PDPS_D3_HOT}, {30'h0, devState});
    check("l1 request", 32'h0000_0001, {31'h0, l1EntryReq});
    for (int i = 0; i < 20 && linkState !== PDPS_L1; i++) idle(1);
    idle(2);
    check("pme held off", 32'h0000_0000, {31'h0, pmeReq});
    for (int k = 0; k < 6; k++) begin
      tlpValid = 1'b1;
      tlpKind = 3'(k);
      #1;
      check("unsupported", {31'h0, k == 0 || k == 1 || k == 3}, {31'h0, tlpUnsupported});
      check("accept", {31'h0, !(k == 0 || k == 1 || k == 3)}, {31'h0, tlpAccept});
      idle(1);
    end
    tlpValid = 1'b0;
    cfgW(PDPS_OFF_PMCSR, 4'h1, 32'h0000_0000);
    idle(2);
    check("no d0 in l1", {30'h0, PDPS_D3_HOT}, {30'h0, devState});
    cfgW(PDPS_OFF_PMCSR, 4'h3, 32'h0000_0103);
    linkCmd(PDPS_L0S_RX);
    check("pme raised", 32'h0000_0001, {31'h0, pmeReq});
    cfgR(PDPS_OFF_PMCSR, 32'h0000_81FF, 32'h0000_8103, "pme status");
    cfgW(PDPS_OFF_PMCSR, 4'h2, 32'h0000_8100);
    idle(2);
    check("pme cleared", 32'h0000_0000, {31'h0, pmeReq});
    cfgW(PDPS_OFF_PMCSR, 4'h1, 32'h0000_0000);
    idle(2);
    check("d0 return", {30'h0, PDPS_D0_UNINIT}, {30'h0, devState});
    check("l1 request off", 32'h0000_0000, {31'h0, l1EntryReq});
    cfgR(PDPS_OFF_COMMAND, 32'h0000_0007, 32'h0000_0000, "command cleared");
    cfgW(PDPS_OFF_COMMAND, 4'h1, 32'h0000_0002);
    idle(2);
    check("active again", {30'h0, PDPS_D0_ACTIVE}, {30'h0, devState});
    for (int s = 0; s < 5; s++) begin
      linkCmd(3'(s));
      check("lanes", {28'h0, laneExp[s]}, {28'h0, txHiZ, txLowPwr, rxLowPwr, fcTimerHold});
    end
    summarize();
  end
endmodule
`default_nettype wire
